// file: hw/pcs_pkg.sv
// Purpose: Shared constants for the four-channel chained PWM block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Overview of operation follows below
//
// Overview of operation
// - Channel 1 follows channel 0, channel 2 follows channel 1 and channel 3 follows channel 2, each half a period behind.
// - A follower's master select field picks its master by value, 0 for channel 0, 1 for channel 1, 2 for channel 2.
// - With its follower enable bit at 1 a channel other than channel 0 restarts its period on its master's sync pulse instead of running free.
// - Followers with identical edge settings give output pairs that match except for the half-period shift.
// - The third waveform offered for routing is the one that has already passed the channel's fault gate.
// - The pin crossbar puts channel 1's third waveform on pin A for select 7 and channel 2's on pin B for select 8.
// - The third waveform rises at the blanking-B begin time and falls at the blanking-B end time.
package pcs_pkg;
   localparam int          NUM_CHAN       = 4;
   localparam int          ADDR_W         = 12;
   localparam int          CNT_W          = 16;
   localparam int          SEL_W          = 4;

   // Per-channel block, 64 bytes each starting at zero
   localparam logic [3:0]  IDX_CTRL       = 4'h0;
   localparam logic [3:0]  IDX_PERIOD     = 4'h1;
   localparam logic [3:0]  IDX_A_ON       = 4'h2;
   localparam logic [3:0]  IDX_A_OFF      = 4'h3;
   localparam logic [3:0]  IDX_B_ON       = 4'h4;
   localparam logic [3:0]  IDX_B_OFF      = 4'h5;
   localparam logic [3:0]  IDX_BLANK_BEG  = 4'h6;
   localparam logic [3:0]  IDX_BLANK_END  = 4'h7;
   localparam logic [3:0]  IDX_SYNC_POS   = 4'h8;
   localparam logic [3:0]  IDX_STATUS     = 4'h9;
   localparam logic [11:0] OFF_MASTER_SEL = 12'h100;

   // Control register fields
   localparam int          CTRL_RUN       = 0;
   localparam int          CTRL_FOLLOW    = 1;
   localparam int          CTRL_A_SEL_LSB = 4;
   localparam int          CTRL_B_SEL_LSB = 8;
   localparam int          CTRL_W         = 12;

   // Status register fields
   localparam int          STAT_FAULT     = 16;
   localparam int          STAT_A         = 17;
   localparam int          STAT_B         = 18;
   localparam int          STAT_C         = 19;
   localparam int          STAT_SYNC      = 20;

   // Master select register: two bits per follower
   localparam int          MSEL_W         = 2;
   localparam logic [1:0]  MSEL_NONE      = 2'h3;

   // Pin crossbar codes
   localparam logic [3:0]  XSEL_OWN       = 4'h0;
   localparam logic [3:0]  XSEL_OWN_C     = 4'h1;
   localparam logic [3:0]  XSEL_C_BASE    = 4'h6;

   // Reset values
   localparam logic [11:0] CTRL_RST_ROOT  = 12'h000;
   localparam logic [11:0] CTRL_RST_FOLW  = 12'h002;
   localparam logic [5:0]  MSEL_RST       = 6'h24;
   localparam logic [15:0] PERIOD_RST     = 16'h0100;
   localparam logic [15:0] A_ON_RST       = 16'h0000;
   localparam logic [15:0] A_OFF_RST      = 16'h0070;
   localparam logic [15:0] B_ON_RST       = 16'h0080;
   localparam logic [15:0] B_OFF_RST      = 16'h00F0;
   localparam logic [15:0] BLANK_BEG_RST  = 16'h0010;
   localparam logic [15:0] BLANK_END_RST  = 16'h0060;
   localparam logic [15:0] SYNC_POS_RST   = 16'h0080;
endpackage : pcs_pkg

// file: hw/pcs_chan_if.sv
// Purpose: Settings and state between the top and one channel timer
// Assumes: Single clock domain
// Notes:   Top drives settings, channel returns counter and waveforms
`timescale 1ns/1ps
`default_nettype none
interface pcs_chan_if #(parameter int CNT_W = 16);
   logic             run;
   logic             follow_en;
   logic             master_sync;
   logic             fault;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] a_on;
   logic [CNT_W-1:0] a_off;
   logic [CNT_W-1:0] b_on;
   logic [CNT_W-1:0] b_off;
   logic [CNT_W-1:0] blank_b_begin_time;
   logic [CNT_W-1:0] blank_b_end_time;
   logic [CNT_W-1:0] sync_pulse_position;
   logic [CNT_W-1:0] count;
   logic             wave_a;
   logic             wave_b;
   logic             third_wave_after_fault;
   logic             sync_pulse;

   modport ctl (output run, follow_en, master_sync, fault, period, a_on, a_off, b_on, b_off,
                blank_b_begin_time, blank_b_end_time, sync_pulse_position,
                input count, wave_a, wave_b, third_wave_after_fault, sync_pulse);
   modport chan (input run, follow_en, master_sync, fault, period, a_on, a_off, b_on, b_off,
                 blank_b_begin_time, blank_b_end_time, sync_pulse_position,
                 output count, wave_a, wave_b, third_wave_after_fault, sync_pulse);
endinterface : pcs_chan_if
`default_nettype wire

// file: hw/pcs_pwm_chan.sv
// Purpose: One channel: period counter, edge compares, fault gate, sync pulse
// Assumes: Settings stable or changed between periods by software
// Notes:   Waveforms and sync come from flip-flops, one cycle after the count
`timescale 1ns/1ps
`default_nettype none
module pcs_pwm_chan #(
   parameter int CNT_W = 16
) (
   input  wire logic clock_in,
   input  wire logic rst_b_in,
   pcs_chan_if.chan  ch
);
   logic [CNT_W-1:0] cnt_reg;
   logic             a_reg;
   logic             b_reg;
   logic             c_reg;
   logic             sync_reg;

   // Compare with >= so a shortened period cannot strand the count
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         cnt_reg <= '0;
      else if (!ch.run)
         cnt_reg <= '0;
      else if (ch.follow_en && ch.master_sync)
         cnt_reg <= '0;
      else if (cnt_reg >= ch.period - CNT_W'(1))
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_reg + CNT_W'(1);
   end

   // Fault gate sits before the outputs, so the routed third wave is gated too
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         a_reg <= 1'b0;
         b_reg <= 1'b0;
         c_reg <= 1'b0;
      end
      else
      begin
         a_reg <= ch.run && !ch.fault && cnt_reg >= ch.a_on && cnt_reg < ch.a_off;
         b_reg <= ch.run && !ch.fault && cnt_reg >= ch.b_on && cnt_reg < ch.b_off;
         c_reg <= ch.run && !ch.fault && cnt_reg >= ch.blank_b_begin_time
                  && cnt_reg < ch.blank_b_end_time;
      end
   end

   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         sync_reg <= 1'b0;
      else
         sync_reg <= ch.run && cnt_reg == ch.sync_pulse_position;
   end

   assign ch.count                  = cnt_reg;
   assign ch.wave_a                 = a_reg;
   assign ch.wave_b                 = b_reg;
   assign ch.third_wave_after_fault = c_reg;
   assign ch.sync_pulse             = sync_reg;
endmodule : pcs_pwm_chan
`default_nettype wire

// file: hw/pcs_pwm_top.sv
// Purpose: Four chained PWM channels with master select and pin crossbar
// Assumes: APB3 master, zero-wait access phase, fault inputs synchronous
// Notes:   Channel 0 is always the root; followers restart two clocks after their master's count reaches its sync position
`timescale 1ns/1ps
`default_nettype none
module pcs_pwm_top #(
   parameter int NUM_CHAN = pcs_pkg::NUM_CHAN,
   parameter int CNT_W    = pcs_pkg::CNT_W
) (
   input  wire logic                        clock_in,
   input  wire logic                        rst_b_in,
   input  wire logic                        psel_in,
   input  wire logic                        penable_in,
   input  wire logic                        pwrite_in,
   input  wire logic [pcs_pkg::ADDR_W-1:0]  paddr_in,
   input  wire logic [31:0]                 pwdata_in,
   output logic      [31:0]                 prdata_out,
   output logic                             pready_out,
   output logic                             pslverr_out,
   input  wire logic [NUM_CHAN-1:0]         fault_in,
   output logic      [NUM_CHAN-1:0]         pwm_a_out,
   output logic      [NUM_CHAN-1:0]         pwm_b_out
);
   localparam int CW = pcs_pkg::CTRL_W;
   localparam int SW = pcs_pkg::SEL_W;

   logic [CW-1:0]    ctrl_reg      [NUM_CHAN];
   logic [CNT_W-1:0] period_reg    [NUM_CHAN];
   logic [CNT_W-1:0] a_on_reg      [NUM_CHAN];
   logic [CNT_W-1:0] a_off_reg     [NUM_CHAN];
   logic [CNT_W-1:0] b_on_reg      [NUM_CHAN];
   logic [CNT_W-1:0] b_off_reg     [NUM_CHAN];
   logic [CNT_W-1:0] blank_beg_reg [NUM_CHAN];
   logic [CNT_W-1:0] blank_end_reg [NUM_CHAN];
   logic [CNT_W-1:0] sync_pos_reg  [NUM_CHAN];
   logic [NUM_CHAN-1:0] fault_seen_reg;
   logic [5:0]       master_sel_reg;
   logic [31:0]      prdata_reg;
   logic             pslverr_reg;
   logic [NUM_CHAN-1:0] pwm_a_reg;
   logic [NUM_CHAN-1:0] pwm_b_reg;

   logic [NUM_CHAN-1:0] sync_vec;
   logic [NUM_CHAN-1:0] third_vec;
   logic [NUM_CHAN-1:0] wave_a_vec;
   logic [NUM_CHAN-1:0] wave_b_vec;
   logic [CNT_W-1:0]    count_vec [NUM_CHAN];

   logic             setup;
   logic             access_wr;
   logic             in_chan;
   logic             is_msel;
   logic [1:0]       chan_idx;
   logic [3:0]       reg_idx;
   logic             addr_ok;
   logic [31:0]      rdata_next;

   // Bus decode: channel blocks below 0x100, master select at 0x100
   assign setup     = psel_in && !penable_in;
   assign access_wr = psel_in && penable_in && pwrite_in && addr_ok;
   assign chan_idx  = paddr_in[7:6];
   assign reg_idx   = paddr_in[5:2];
   assign in_chan   = paddr_in[11:8] == 4'h0 && paddr_in[1:0] == 2'h0
                      && reg_idx <= pcs_pkg::IDX_STATUS && 32'(chan_idx) < NUM_CHAN;
   assign is_msel   = paddr_in == pcs_pkg::OFF_MASTER_SEL;
   assign addr_ok   = in_chan || is_msel;

   function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
      widen = 32'(v);
   endfunction : widen

   // Crossbar: own waveform, own third wave, or any channel's third wave
   function automatic logic route(input logic [SW-1:0] sel, input logic own,
                                  input logic own_c, input logic [NUM_CHAN-1:0] cv);
      logic [SW-1:0] k;
      k = sel - pcs_pkg::XSEL_C_BASE;
      if (sel == pcs_pkg::XSEL_OWN)
         route = own;
      else if (sel == pcs_pkg::XSEL_OWN_C)
         route = own_c;
      else if (sel >= pcs_pkg::XSEL_C_BASE && 32'(k) < NUM_CHAN)
         route = cv[k[1:0]];
      else
         route = 1'b0;
   endfunction : route

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (is_msel)
         rdata_next = 32'(master_sel_reg);
      else if (in_chan)
      begin
         case (reg_idx)
            pcs_pkg::IDX_CTRL:      rdata_next = 32'(ctrl_reg[chan_idx]);
            pcs_pkg::IDX_PERIOD:    rdata_next = widen(period_reg[chan_idx]);
            pcs_pkg::IDX_A_ON:      rdata_next = widen(a_on_reg[chan_idx]);
            pcs_pkg::IDX_A_OFF:     rdata_next = widen(a_off_reg[chan_idx]);
            pcs_pkg::IDX_B_ON:      rdata_next = widen(b_on_reg[chan_idx]);
            pcs_pkg::IDX_B_OFF:     rdata_next = widen(b_off_reg[chan_idx]);
            pcs_pkg::IDX_BLANK_BEG: rdata_next = widen(blank_beg_reg[chan_idx]);
            pcs_pkg::IDX_BLANK_END: rdata_next = widen(blank_end_reg[chan_idx]);
            pcs_pkg::IDX_SYNC_POS:  rdata_next = widen(sync_pos_reg[chan_idx]);
            pcs_pkg::IDX_STATUS:
            begin
               rdata_next = widen(count_vec[chan_idx]);
               rdata_next[pcs_pkg::STAT_FAULT] = fault_seen_reg[chan_idx];
               rdata_next[pcs_pkg::STAT_A]     = wave_a_vec[chan_idx];
               rdata_next[pcs_pkg::STAT_B]     = wave_b_vec[chan_idx];
               rdata_next[pcs_pkg::STAT_C]     = third_vec[chan_idx];
               rdata_next[pcs_pkg::STAT_SYNC]  = sync_vec[chan_idx];
            end
            default:                rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Read data and error are latched in the setup cycle, so the access is zero-wait
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else if (setup)
      begin
         prdata_reg  <= pwrite_in ? 32'h0000_0000 : rdata_next;
         pslverr_reg <= !addr_ok;
      end
   end

   assign pready_out  = 1'b1;
   assign prdata_out  = prdata_reg;
   assign pslverr_out = pslverr_reg && psel_in && penable_in;

   // Default 0,1,2 forms the chain 0 -> 1 -> 2 -> 3 out of reset
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         master_sel_reg <= pcs_pkg::MSEL_RST;
      else if (access_wr && is_msel)
         master_sel_reg <= pwdata_in[5:0];
   end

   genvar i;
   generate
      for (i = 0; i < NUM_CHAN; i++)
      begin : g_chan
         pcs_chan_if #(.CNT_W(CNT_W)) cif ();
         logic          wr_here;
         logic [1:0]    msel;
         logic [SW-1:0] a_sel;
         logic [SW-1:0] b_sel;

         assign wr_here = access_wr && in_chan && chan_idx == 2'(i);
         assign a_sel   = ctrl_reg[i][pcs_pkg::CTRL_A_SEL_LSB +: SW];
         assign b_sel   = ctrl_reg[i][pcs_pkg::CTRL_B_SEL_LSB +: SW];
         if (i == 0)
            assign msel = pcs_pkg::MSEL_NONE;
         else
            assign msel = master_sel_reg[(i-1)*pcs_pkg::MSEL_W +: pcs_pkg::MSEL_W];

         always_ff @(posedge clock_in or negedge rst_b_in)
         begin
            if (!rst_b_in)
            begin
               ctrl_reg[i]      <= (i == 0) ? pcs_pkg::CTRL_RST_ROOT : pcs_pkg::CTRL_RST_FOLW;
               period_reg[i]    <= CNT_W'(pcs_pkg::PERIOD_RST);
               a_on_reg[i]      <= CNT_W'(pcs_pkg::A_ON_RST);
               a_off_reg[i]     <= CNT_W'(pcs_pkg::A_OFF_RST);
               b_on_reg[i]      <= CNT_W'(pcs_pkg::B_ON_RST);
               b_off_reg[i]     <= CNT_W'(pcs_pkg::B_OFF_RST);
               blank_beg_reg[i] <= CNT_W'(pcs_pkg::BLANK_BEG_RST);
               blank_end_reg[i] <= CNT_W'(pcs_pkg::BLANK_END_RST);
               sync_pos_reg[i]  <= CNT_W'(pcs_pkg::SYNC_POS_RST);
            end
            else if (wr_here)
            begin
               case (reg_idx)
                  pcs_pkg::IDX_CTRL:      ctrl_reg[i]      <= pwdata_in[CW-1:0];
                  pcs_pkg::IDX_PERIOD:    period_reg[i]    <= pwdata_in[CNT_W-1:0];
                  pcs_pkg::IDX_A_ON:      a_on_reg[i]      <= pwdata_in[CNT_W-1:0];
                  pcs_pkg::IDX_A_OFF:     a_off_reg[i]     <= pwdata_in[CNT_W-1:0];
                  pcs_pkg::IDX_B_ON:      b_on_reg[i]      <= pwdata_in[CNT_W-1:0];
                  pcs_pkg::IDX_B_OFF:     b_off_reg[i]     <= pwdata_in[CNT_W-1:0];
                  pcs_pkg::IDX_BLANK_BEG: blank_beg_reg[i] <= pwdata_in[CNT_W-1:0];
                  pcs_pkg::IDX_BLANK_END: blank_end_reg[i] <= pwdata_in[CNT_W-1:0];
                  pcs_pkg::IDX_SYNC_POS:  sync_pos_reg[i]  <= pwdata_in[CNT_W-1:0];
                  default:                ;
               endcase
            end
         end

         // Sticky fault flag, write one to clear; a new fault beats the clear
         always_ff @(posedge clock_in or negedge rst_b_in)
         begin
            if (!rst_b_in)
               fault_seen_reg[i] <= 1'b0;
            else if (fault_in[i])
               fault_seen_reg[i] <= 1'b1;
            else if (wr_here && reg_idx == pcs_pkg::IDX_STATUS && pwdata_in[pcs_pkg::STAT_FAULT])
               fault_seen_reg[i] <= 1'b0;
         end

         assign cif.run                 = ctrl_reg[i][pcs_pkg::CTRL_RUN];
         // Channel 0 ignores its follower bit and is never restarted
         assign cif.follow_en           = (i != 0) && ctrl_reg[i][pcs_pkg::CTRL_FOLLOW];
         // Code 3 leaves the follower without a master
         assign cif.master_sync         = (msel == pcs_pkg::MSEL_NONE) ? 1'b0 : sync_vec[msel];
         assign cif.fault               = fault_in[i];
         assign cif.period              = period_reg[i];
         assign cif.a_on                = a_on_reg[i];
         assign cif.a_off               = a_off_reg[i];
         assign cif.b_on                = b_on_reg[i];
         assign cif.b_off               = b_off_reg[i];
         assign cif.blank_b_begin_time  = blank_beg_reg[i];
         assign cif.blank_b_end_time    = blank_end_reg[i];
         assign cif.sync_pulse_position = sync_pos_reg[i];

         // Same timer for every channel keeps equal settings symmetrical
         pcs_pwm_chan #(.CNT_W(CNT_W)) u_chan (
            .clock_in (clock_in),
            .rst_b_in (rst_b_in),
            .ch       (cif)
         );

         assign sync_vec[i]   = cif.sync_pulse;
         assign third_vec[i]  = cif.third_wave_after_fault;
         assign wave_a_vec[i] = cif.wave_a;
         assign wave_b_vec[i] = cif.wave_b;
         assign count_vec[i]  = cif.count;

         always_ff @(posedge clock_in or negedge rst_b_in)
         begin
            if (!rst_b_in)
            begin
               pwm_a_reg[i] <= 1'b0;
               pwm_b_reg[i] <= 1'b0;
            end
            else
            begin
               pwm_a_reg[i] <= route(a_sel, wave_a_vec[i], third_vec[i], third_vec);
               pwm_b_reg[i] <= route(b_sel, wave_b_vec[i], third_vec[i], third_vec);
            end
         end
      end
   endgenerate

   assign pwm_a_out = pwm_a_reg;
   assign pwm_b_out = pwm_b_reg;
endmodule : pcs_pwm_top
`default_nettype wire

// file: test/pcs_gate_model.sv
// Purpose: Gate driver model at the bridge side, notes edge times of every pin
// Assumes: Pins are level signals, sampled on clock_in
// Notes:   Inputs only; real drivers give the block no feedback
`timescale 1ns/1ps
`default_nettype none
module pcs_gate_model (
   input  wire logic        clock_in,
   input  wire logic        rst_b_in,
   input  wire logic [7:0]  pins_in,
   output logic      [31:0] rise_out [8],
   output logic      [31:0] width_out [8]
);
   logic [31:0] cyc_reg;
   logic [7:0]  last_reg;

   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         cyc_reg  <= '0;
         last_reg <= '0;
      end
      else
      begin
         cyc_reg  <= cyc_reg + 32'h1;
         last_reg <= pins_in;
      end
   end

   // Width is taken at the falling edge, so it holds the pulse that has just ended
   always_ff @(posedge clock_in)
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (pins_in[i] && !last_reg[i]) rise_out[i] <= cyc_reg;
         if (!pins_in[i] && last_reg[i]) width_out[i] <= cyc_reg - rise_out[i];
      end
   end
endmodule : pcs_gate_model
`default_nettype wire

// file: test/pcs_pwm_properties.sv
// Purpose: Port-level checker for the chained PWM block
// Assumes: Bench keeps channel 0 pin selects at their own waveforms
// Notes:   Bound into every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module pcs_pwm_properties #(
   parameter int NUM_CHAN = 4,
   parameter int CNT_W    = 16
) (
   input wire logic                       clock_in,
   input wire logic                       rst_b_in,
   input wire logic                       psel_in,
   input wire logic                       penable_in,
   input wire logic                       pwrite_in,
   input wire logic [pcs_pkg::ADDR_W-1:0] paddr_in,
   input wire logic [31:0]                pwdata_in,
   input wire logic [31:0]                prdata_out,
   input wire logic                       pready_out,
   input wire logic                       pslverr_out,
   input wire logic [NUM_CHAN-1:0]        fault_in,
   input wire logic [NUM_CHAN-1:0]        pwm_a_out,
   input wire logic [NUM_CHAN-1:0]        pwm_b_out
);
   wire logic acc;
   assign acc = psel_in && penable_in;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);

   AST_PREADY: assert property (acc |-> pready_out)
      else $error("pready low in access phase");
   AST_ERR_ACCESS_ONLY: assert property (pslverr_out |-> acc)
      else $error("pslverr outside access phase");
   AST_ERR_MISALIGN: assert property (acc && paddr_in[1:0] != 2'h0 |-> pslverr_out)
      else $error("misaligned access not refused");
   AST_ERR_HOLE: assert property (acc && paddr_in < 12'h100 && paddr_in[5:2] > 4'h9 |-> pslverr_out)
      else $error("hole in channel block not refused");
   AST_MSEL_OK: assert property (acc && paddr_in == 12'h100 |-> !pslverr_out)
      else $error("master select access refused");
   AST_ERR_READ_ZERO: assert property (acc && !pwrite_in && pslverr_out |-> prdata_out == 32'h0)
      else $error("refused read returns data");
   AST_RESET_QUIET: assert property ($rose(rst_b_in) |-> (pwm_a_out == '0 && pwm_b_out == '0) [*3])
      else $error("pins active after reset");
   AST_FAULT_GATE: assert property (fault_in[0] |-> ##2 !pwm_a_out[0] && !pwm_b_out[0])
      else $error("fault did not gate channel 0 pins");

   cover property (acc && pwrite_in);
   cover property (acc && pslverr_out);
   cover property ($rose(pwm_a_out[3]));
   cover property ($rose(fault_in[0]));
endmodule : pcs_pwm_properties

bind pcs_pwm_top pcs_pwm_properties #(.NUM_CHAN(NUM_CHAN), .CNT_W(CNT_W)) u_props (
   .clock_in(clock_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .fault_in(fault_in),
   .pwm_a_out(pwm_a_out), .pwm_b_out(pwm_b_out));
`default_nettype wire

// file: test/test_pcs_pwm_top.sv
// Purpose: Self-checking bench for the chained PWM block
// Assumes: Zero-wait APB slave; period shrunk to keep the run short
// Notes:   Phase and width are judged from edge times seen by the gate model
`timescale 1ns/1ps
`default_nettype none
module test_pcs_pwm_top;
   localparam int P = 32;
   logic        clk = 1'b0;
   logic        rst_b, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  fault, pwm_a, pwm_b;
   logic [31:0] rise [8];
   logic [31:0] width [8];
   int          mismatches = 0;
   int          num_checks = 0;
   int          cycles = 0;

   always #4 clk = ~clk;

   pcs_pwm_top u_dut (.clock_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .fault_in(fault), .pwm_a_out(pwm_a), .pwm_b_out(pwm_b));
   pcs_gate_model u_gate (.clock_in(clk), .rst_b_in(rst_b), .pins_in({pwm_b, pwm_a}),
      .rise_out(rise), .width_out(width));

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         complete_run();
      end
   end

   function automatic logic [11:0] adr(input int c, input logic [3:0] idx);
      return 12'(c * 64) + {6'h00, idx, 2'h0};
   endfunction : adr

   function automatic logic [31:0] lag(input int a, input int b);
      return (rise[a] - rise[b] + 32'(64 * P)) % 32'(P);
   endfunction : lag

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk({31'h0, pready}, 32'h1);
   endtask : apb

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic err);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp);
      chk({31'h0, e}, {31'h0, err});
   endtask : rchk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic t_reset;
      chk({24'h0, pwm_a, pwm_b}, 32'h0);
      rchk(adr(0, pcs_pkg::IDX_CTRL), 32'(pcs_pkg::CTRL_RST_ROOT), 1'b0);
      rchk(adr(1, pcs_pkg::IDX_CTRL), 32'(pcs_pkg::CTRL_RST_FOLW), 1'b0);
      rchk(pcs_pkg::OFF_MASTER_SEL, 32'(pcs_pkg::MSEL_RST), 1'b0);
      rchk(adr(2, pcs_pkg::IDX_PERIOD), 32'(pcs_pkg::PERIOD_RST), 1'b0);
      rchk(adr(3, pcs_pkg::IDX_BLANK_BEG), 32'(pcs_pkg::BLANK_BEG_RST), 1'b0);
      rchk(adr(3, pcs_pkg::IDX_BLANK_END), 32'(pcs_pkg::BLANK_END_RST), 1'b0);
      rchk(adr(0, pcs_pkg::IDX_SYNC_POS), 32'(pcs_pkg::SYNC_POS_RST), 1'b0);
   endtask : t_reset

   task automatic t_unmapped;
      logic [31:0] q;
      logic        e;
      apb(1'b1, 12'h046, 32'h0000_0055, q, e);
      chk({31'h0, e}, 32'h1);
      rchk(adr(1, pcs_pkg::IDX_PERIOD), 32'(pcs_pkg::PERIOD_RST), 1'b0);
      rchk(12'h028, 32'h0, 1'b1);
      rchk(12'h0FC, 32'h0, 1'b1);
      rchk(12'h006, 32'h0, 1'b1);
      rchk(12'h104, 32'h0, 1'b1);
   endtask : t_unmapped

   task automatic t_chain;
      logic [31:0] d;
      for (int c = 0; c < 4; c++)
      begin
         wr(adr(c, pcs_pkg::IDX_PERIOD), 32'(P));
         wr(adr(c, pcs_pkg::IDX_A_OFF), 32'h8);
         wr(adr(c, pcs_pkg::IDX_B_ON), 32'(P / 2));
         wr(adr(c, pcs_pkg::IDX_B_OFF), 32'(P / 2 + 8));
         wr(adr(c, pcs_pkg::IDX_SYNC_POS), 32'(P / 2));
         wr(adr(c, pcs_pkg::IDX_CTRL), (c == 0) ? 32'h1 : 32'h3);
      end
      repeat (8 * P) @(posedge clk);
      for (int c = 0; c < 8; c++) chk(width[c], 32'h8);
      d = lag(1, 0);
      chk({31'h0, d >= 32'(P / 2) && d <= 32'(P / 2 + 2)}, 32'h1);
      chk(lag(2, 1), d);
      chk(lag(3, 2), d);
      chk(lag(5, 4), d);
      wr(pcs_pkg::OFF_MASTER_SEL, 32'h20);
      repeat (4 * P) @(posedge clk);
      chk(lag(2, 0), d);
      chk(lag(3, 2), d);
      wr(pcs_pkg::OFF_MASTER_SEL, 32'(pcs_pkg::MSEL_RST));
   endtask : t_chain

   task automatic t_xbar;
      logic        ha;
      logic        hb;
      logic [31:0] q;
      logic        e;
      wr(adr(1, pcs_pkg::IDX_BLANK_BEG), 32'h4);
      wr(adr(1, pcs_pkg::IDX_BLANK_END), 32'hC);
      wr(adr(2, pcs_pkg::IDX_BLANK_BEG), 32'h2);
      wr(adr(2, pcs_pkg::IDX_BLANK_END), 32'hC);
      // Pin A takes code 7, pin B code 8, channel keeps running as follower
      wr(adr(3, pcs_pkg::IDX_CTRL), 32'h0000_0873);
      repeat (4 * P) @(posedge clk);
      chk(width[3], 32'h8);
      chk(width[7], 32'hA);
      chk(lag(3, 1), 32'h4);
      chk(lag(7, 2), 32'h2);
      fault <= 4'h3;
      repeat (3) @(posedge clk);
      ha = 1'b0;
      hb = 1'b0;
      // Mid-cycle sampling keeps the read clear of the pin update at the edge
      repeat (P)
      begin
         @(negedge clk);
         ha = ha | pwm_a[3] | pwm_a[0];
         hb = hb | pwm_b[3];
      end
      chk({31'h0, ha}, 32'h0);
      chk({31'h0, hb}, 32'h1);
      @(posedge clk);
      fault <= 4'h0;
      apb(1'b0, adr(0, pcs_pkg::IDX_STATUS), 32'h0, q, e);
      chk((q >> pcs_pkg::STAT_FAULT) & 32'h1, 32'h1);
      wr(adr(0, pcs_pkg::IDX_STATUS), 32'h1 << pcs_pkg::STAT_FAULT);
      apb(1'b0, adr(0, pcs_pkg::IDX_STATUS), 32'h0, q, e);
      chk((q >> pcs_pkg::STAT_FAULT) & 32'h1, 32'h0);
   endtask : t_xbar

   initial
   begin
      rst_b   = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      fault   = 4'h0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_unmapped();
      t_chain();
      t_xbar();
      complete_run();
   end
endmodule : test_pcs_pwm_top
`default_nettype wire
